// ---- adcrc_pkg.sv ----
// Shared constants and types for the converter control register block
package adcrc_pkg;

	// Register offsets
	localparam logic [7:0] ADCRC_CONTROL_OFFSET = 8'h16;
	localparam logic [7:0] ADCRC_RESULT_LOW_OFFSET = 8'h17;
	localparam logic [7:0] ADCRC_RESULT_HIGH_OFFSET = 8'h18;
	localparam logic [7:0] ADCRC_SCRATCH_OFFSET = 8'h1b;

	// Control register fields
	localparam int ADCRC_START_POS = 6;
	localparam int ADCRC_DONE_POS = 5;
	localparam int ADCRC_REF_POS = 4;
	localparam int ADCRC_CHANNEL_MSB = 3;

	// Scratch register fields
	localparam int ADCRC_RELOAD_POS = 7;

	// Reset values
	localparam logic ADCRC_START_RESET = 1'b0;
	localparam logic ADCRC_DONE_RESET = 1'b1;
	localparam logic ADCRC_REF_RESET = 1'b0;
	localparam logic [3:0] ADCRC_CHANNEL_RESET = 4'h0;
	localparam logic [9:0] ADCRC_RESULT_RESET = 10'h000;
	localparam logic [6:0] ADCRC_SCRATCH_RESET = 7'h00;

	// Serial interface
	localparam logic [6:0] ADCRC_DEVICE_ADDRESS = 7'h48;
	localparam logic [3:0] ADCRC_BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ADCRC_ST_IDLE = 4'b0000,
		ADCRC_ST_ADDR = 4'b0001,
		ADCRC_ST_ACK_ADDR = 4'b0010,
		ADCRC_ST_PTR = 4'b0011,
		ADCRC_ST_ACK_PTR = 4'b0100,
		ADCRC_ST_WRITE = 4'b0101,
		ADCRC_ST_ACK_WRITE = 4'b0110,
		ADCRC_ST_READ = 4'b0111,
		ADCRC_ST_READ_ACK = 4'b1000
	} adcrc_serial_state_type;

endpackage

// ---- adcrc_serial_slave.sv ----
// Two-wire serial slave that turns bus transfers into register reads and writes
`timescale 1ns/1ps
module adcrc_serial_slave
	import adcrc_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDRESS = ADCRC_DEVICE_ADDRESS
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	output logic write_strobe,
	output logic [7:0] write_data,
	output logic [7:0] reg_pointer,
	input wire logic [7:0] read_data
);

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_prev;
	logic sda_prev;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt;
	logic read_mode;
	logic master_ack;
	adcrc_serial_state_type state;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edge detection only looks at the second stage
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else if (clk_en) begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] & ~scl_prev;
	assign scl_fall = ~scl_sync[1] & scl_prev;
	assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
	assign stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Byte engine
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= ADCRC_ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt <= 4'h0;
			read_mode <= 1'b0;
			master_ack <= 1'b0;
			sda_oe <= 1'b0;
			write_strobe <= 1'b0;
			write_data <= 8'h00;
			reg_pointer <= 8'h00;
		end else if (clk_en) begin
			write_strobe <= 1'b0;
			if (start_seen) begin
				state <= ADCRC_ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				state <= ADCRC_ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					ADCRC_ST_ADDR, ADCRC_ST_PTR, ADCRC_ST_WRITE: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_sync[1]};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == ADCRC_BITS_PER_BYTE) begin
							bit_cnt <= 4'h0;
							sda_oe <= 1'b1;
							if (state == ADCRC_ST_ADDR) begin
								if (shift_reg[7:1] == DEVICE_ADDRESS) begin
									read_mode <= shift_reg[0];
									state <= ADCRC_ST_ACK_ADDR;
								end else begin
									sda_oe <= 1'b0;
									state <= ADCRC_ST_IDLE;
								end
							end else if (state == ADCRC_ST_PTR) begin
								reg_pointer <= shift_reg;
								state <= ADCRC_ST_ACK_PTR;
							end else begin
								write_data <= shift_reg;
								write_strobe <= 1'b1;
								state <= ADCRC_ST_ACK_WRITE;
							end
						end
					end
					ADCRC_ST_ACK_ADDR: begin
						if (scl_fall) begin
							if (read_mode) begin
								shift_reg <= read_data;
								sda_oe <= ~read_data[7];
								bit_cnt <= 4'h1;
								state <= ADCRC_ST_READ;
							end else begin
								sda_oe <= 1'b0;
								state <= ADCRC_ST_PTR;
							end
						end
					end
					ADCRC_ST_ACK_PTR: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state <= ADCRC_ST_WRITE;
						end
					end
					ADCRC_ST_ACK_WRITE: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							reg_pointer <= reg_pointer + 8'h01;
							state <= ADCRC_ST_WRITE;
						end
					end
					ADCRC_ST_READ: begin
						if (scl_fall) begin
							if (bit_cnt == ADCRC_BITS_PER_BYTE) begin
								sda_oe <= 1'b0;
								reg_pointer <= reg_pointer + 8'h01;
								state <= ADCRC_ST_READ_ACK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								sda_oe <= ~shift_reg[6];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					ADCRC_ST_READ_ACK: begin
						if (scl_rise) begin
							master_ack <= ~sda_sync[1];
						end else if (scl_fall) begin
							// A refused byte ends the read; the master then sends stop
							if (master_ack) begin
								shift_reg <= read_data;
								sda_oe <= ~read_data[7];
								bit_cnt <= 4'h1;
								state <= ADCRC_ST_READ;
							end else begin
								state <= ADCRC_ST_IDLE;
							end
						end
					end
					default: begin
						state <= ADCRC_ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ---- adcrc_control.sv ----
// Converter control registers reached over the two-wire serial interface
`timescale 1ns/1ps
// What this block does
// - Writing start launches one conversion; the bit self-clears when it completes.
// - Done flag reads zero during a conversion, one afterwards; resets to one.
// - Reference enable bit switches the converter reference; resets to zero.
// - Four-bit channel field routes one of fourteen inputs; top two codes unused.
// - Result bits seven to zero read at 0x17; reset zero.
// - Result bits nine and eight read at 0x18 low bits; rest zero.
// - Writing one to bit seven at 0x1B restores register defaults; bit reads zero.
// - Low seven bits at 0x1B are plain user storage, reset zero.
module adcrc_control
	import adcrc_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDRESS = ADCRC_DEVICE_ADDRESS
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic converter_start,
	output logic reference_enable,
	output logic [3:0] channel_select,
	output logic register_reload,
	input wire logic converter_done,
	input wire logic [9:0] converter_result
);

	logic write_strobe;
	logic [7:0] write_data;
	logic [7:0] reg_pointer;
	logic [7:0] read_data;
	logic conversion_start_bit;
	logic conversion_done_flag;
	logic [9:0] result_data;
	logic [6:0] user_scratch_bits;
	logic reload_pending;
	logic control_write;
	logic scratch_write;

	////////////////////////////////////////////////////////////////////////////////
	// Serial register access
	adcrc_serial_slave #(
		.DEVICE_ADDRESS(DEVICE_ADDRESS)
	) u_serial (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.write_strobe(write_strobe),
		.write_data(write_data),
		.reg_pointer(reg_pointer),
		.read_data(read_data)
	);

	// Open-drain line: only ever pulled low
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sda_out <= 1'b0;
		end else if (clk_en) begin
			sda_out <= 1'b0;
		end
	end

	assign control_write = write_strobe && reg_pointer == ADCRC_CONTROL_OFFSET;
	assign scratch_write = write_strobe && reg_pointer == ADCRC_SCRATCH_OFFSET;

	////////////////////////////////////////////////////////////////////////////////
	// Register reload: defaults are restored two cycles after the write strobe
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reload_pending <= 1'b0;
			register_reload <= 1'b0;
		end else if (clk_en) begin
			reload_pending <= scratch_write && write_data[ADCRC_RELOAD_POS];
			register_reload <= reload_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference and channel
	// A pending reload also waits for the clock enable, so a frozen block keeps its state
	always_ff @(posedge clk_sys) begin
		if (reset || (clk_en && reload_pending)) begin
			reference_enable <= ADCRC_REF_RESET;
			channel_select <= ADCRC_CHANNEL_RESET;
		end else if (clk_en && control_write) begin
			reference_enable <= write_data[ADCRC_REF_POS];
			// Unused codes are stored as written; the converter sees them unchanged
			channel_select <= write_data[ADCRC_CHANNEL_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencing
	always_ff @(posedge clk_sys) begin
		if (reset || (clk_en && reload_pending)) begin
			conversion_start_bit <= ADCRC_START_RESET;
			conversion_done_flag <= ADCRC_DONE_RESET;
			converter_start <= 1'b0;
		end else if (clk_en) begin
			converter_start <= 1'b0;
			if (conversion_start_bit && converter_done) begin
				conversion_start_bit <= 1'b0;
				conversion_done_flag <= 1'b1;
			end else if (control_write && write_data[ADCRC_START_POS] && !conversion_start_bit) begin
				// A second start while busy is ignored; only reset or a register reload abandons a running conversion
				conversion_start_bit <= 1'b1;
				conversion_done_flag <= 1'b0;
				converter_start <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || (clk_en && reload_pending)) begin
			result_data <= ADCRC_RESULT_RESET;
		end else if (clk_en && conversion_start_bit && converter_done) begin
			result_data <= converter_result;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// User storage
	always_ff @(posedge clk_sys) begin
		if (reset || (clk_en && reload_pending)) begin
			user_scratch_bits <= ADCRC_SCRATCH_RESET;
		end else if (clk_en && scratch_write) begin
			user_scratch_bits <= write_data[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets read zero
	always_comb begin
		read_data = 8'h00;
		case (reg_pointer)
			ADCRC_CONTROL_OFFSET: begin
				read_data[ADCRC_START_POS] = conversion_start_bit;
				read_data[ADCRC_DONE_POS] = conversion_done_flag;
				read_data[ADCRC_REF_POS] = reference_enable;
				read_data[ADCRC_CHANNEL_MSB:0] = channel_select;
			end
			ADCRC_RESULT_LOW_OFFSET: begin
				read_data = result_data[7:0];
			end
			ADCRC_RESULT_HIGH_OFFSET: begin
				read_data[1:0] = result_data[9:8];
			end
			ADCRC_SCRATCH_OFFSET: begin
				read_data[6:0] = user_scratch_bits;
			end
			default: begin
				read_data = 8'h00;
			end
		endcase
	end

endmodule

// ---- adcrc_checker.sv ----
// Port assertions for the converter control block
`timescale 1ns/1ps
module adcrc_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic converter_start,
	input wire logic reference_enable,
	input wire logic [3:0] channel_select,
	input wire logic register_reload,
	input wire logic converter_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic busy;
	// Mirror of a running conversion so a second launch is caught
	always_ff @(posedge clk_sys) begin
		if (reset || converter_done || register_reload) begin
			busy <= 1'b0;
		end else if (converter_start) begin
			busy <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	AST_START_PULSE: assert property (converter_start |=> !converter_start)
		else $error("start longer than one cycle");
	AST_START_IDLE: assert property (converter_start |-> !busy)
		else $error("start while busy");
	AST_START_BUS: assert property (converter_start |-> !scl_in)
		else $error("start outside a write");
	AST_RELOAD_PULSE: assert property (register_reload |=> !register_reload)
		else $error("reload longer than one cycle");
	AST_RELOAD_DEFAULTS: assert property (register_reload |-> !reference_enable && channel_select == 4'h0)
		else $error("reload without defaults");
	AST_REF_BUS: assert property ($changed(reference_enable) |-> !scl_in)
		else $error("reference changed outside a write");
	AST_CHANNEL_BUS: assert property ($changed(channel_select) |-> !scl_in)
		else $error("channel changed outside a write");
	AST_RESET_VALUES: assert property ($fell(reset) |-> !reference_enable && channel_select == 4'h0)
		else $error("bad values after reset");
	AST_DATA_DRIVE: assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
		else $error("data driven while clock high");
	COV_START: cover property (converter_start);
	COV_DONE: cover property (busy && converter_done);
	COV_RELOAD: cover property (register_reload);
endmodule
bind adcrc_control adcrc_checker i_adcrc_checker (
	.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.converter_start(converter_start), .reference_enable(reference_enable),
	.channel_select(channel_select), .register_reload(register_reload), .converter_done(converter_done)
);

// ---- adcrc_conv_model.sv ----
// Behavioural converter that answers a launch after a fixed delay
`timescale 1ns/1ps
module adcrc_conv_model #(
	parameter int DELAY = 3000,
	parameter logic [9:0] VALUE = 10'h2a5
) (
	input wire logic clk_sys,
	input wire logic converter_start,
	output logic converter_done,
	output logic [9:0] converter_result,
	output int n_start
);
	int cnt = 0;
	initial begin
		converter_done = 1'b0;
		converter_result = 10'h000;
		n_start = 0;
	end
	// Result toggles outside the done cycle so a stray capture shows
	always @(posedge clk_sys) begin
		converter_done <= #1 (cnt == 1);
		converter_result <= #1 (cnt == 1) ? VALUE : ~converter_result;
		if (converter_start) begin
			n_start <= n_start + 1;
			cnt <= DELAY;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the converter control registers
`timescale 1ns/1ps
module tb_top;
	import adcrc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic scl = 1'b1;
	logic tb_low = 1'b0;
	logic clk_en = 1'b1;
	logic sda_out, sda_oe, converter_start, reference_enable, register_reload, converter_done;
	logic [3:0] channel_select;
	logic [9:0] converter_result;
	int n_errors = 0;
	int samples_checked = 0;
	int n_start;
	int n_reload = 0;
	// Open-drain data line with its pull-up
	// The device drives its output value only while enabled; released, the pull-up wins
	wire sda_line = !tb_low && (!sda_oe || sda_out);
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	adcrc_control i_adcrc_control (
		.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .converter_start(converter_start),
		.reference_enable(reference_enable), .channel_select(channel_select),
		.register_reload(register_reload), .converter_done(converter_done),
		.converter_result(converter_result)
	);
	adcrc_conv_model i_adcrc_conv_model (
		.clk_sys(clk_sys), .converter_start(converter_start), .converter_done(converter_done),
		.converter_result(converter_result), .n_start(n_start)
	);
	always @(posedge clk_sys) begin
		n_reload <= n_reload + int'(register_reload);
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Start when stop is 0; the data line flips while the clock is high
	task automatic cond(input logic stop);
		tb_low = stop;
		tick(8);
		scl = 1'b1;
		tick(8);
		tb_low = !stop;
		tick(8);
		if (!stop) begin
			scl = 1'b0;
		end
	endtask
	task automatic xfer(input logic [7:0] d, input logic tx, input logic ack, output logic [7:0] q, output logic k);
		for (int i = 8; i >= 0; i--) begin
			tb_low = (i == 0) ? (!tx && ack) : (tx && !d[i - 1]);
			tick(8);
			scl = 1'b1;
			tick(4);
			if (i == 0) begin
				k = !sda_line;
			end else begin
				q[i - 1] = sda_line;
			end
			tick(4);
			scl = 1'b0;
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic k;
		cond(1'b0);
		xfer({ADCRC_DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b0, q, k);
		xfer(a, 1'b1, 1'b0, q, k);
		xfer(d, 1'b1, 1'b0, q, k);
		chk({7'h00, k}, 8'h01);
		cond(1'b1);
	endtask
	// Pointer write, repeated start, one byte read ended by a nack
	task automatic rb(input logic [7:0] a, output logic [7:0] q);
		logic k;
		cond(1'b0);
		xfer({ADCRC_DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b0, q, k);
		xfer(a, 1'b1, 1'b0, q, k);
		cond(1'b0);
		xfer({ADCRC_DEVICE_ADDRESS, 1'b1}, 1'b1, 1'b0, q, k);
		xfer(8'h00, 1'b0, 1'b0, q, k);
		cond(1'b1);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		rb(a, q);
		chk(q, e);
	endtask
	task automatic end_sim;
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] q;
		logic k;
		tick(12);
		reset = 1'b0;
		tick(4);
		rc(ADCRC_CONTROL_OFFSET, 8'h20);
		rc(ADCRC_RESULT_LOW_OFFSET, 8'h00);
		rc(ADCRC_RESULT_HIGH_OFFSET, 8'h00);
		rc(ADCRC_SCRATCH_OFFSET, 8'h00);
		rc(8'h30, 8'h00);
		$display("test reset_values done");
		for (int c = 0; c < 16; c++) begin
			wb(ADCRC_CONTROL_OFFSET, 8'h10 | 8'(c));
			chk({3'b000, reference_enable, channel_select}, 8'h10 | 8'(c));
		end
		rc(ADCRC_CONTROL_OFFSET, 8'h3f);
		wb(ADCRC_CONTROL_OFFSET, 8'h05);
		chk({3'b000, reference_enable, channel_select}, 8'h05);
		$display("test channel_reference done");
		// Second launch and result writes land while busy and must be ignored
		wb(ADCRC_CONTROL_OFFSET, 8'h53);
		rc(ADCRC_CONTROL_OFFSET, 8'h53);
		wb(ADCRC_CONTROL_OFFSET, 8'h53);
		wb(ADCRC_RESULT_LOW_OFFSET, 8'hff);
		q = 8'h00;
		for (int w = 0; w < 8 && q[5] !== 1'b1; w++) begin
			rb(ADCRC_CONTROL_OFFSET, q);
		end
		chk(q, 8'h33);
		rc(ADCRC_RESULT_LOW_OFFSET, 8'ha5);
		rc(ADCRC_RESULT_HIGH_OFFSET, 8'h02);
		chk(8'(n_start), 8'h01);
		$display("test conversion done");
		wb(ADCRC_SCRATCH_OFFSET, 8'h2a);
		rc(ADCRC_SCRATCH_OFFSET, 8'h2a);
		wb(ADCRC_SCRATCH_OFFSET, 8'h55);
		rc(ADCRC_SCRATCH_OFFSET, 8'h55);
		// Frozen by the clock enable: the frame goes unseen, no ack and no write
		clk_en = 1'b0;
		cond(1'b0);
		xfer({ADCRC_DEVICE_ADDRESS, 1'b0}, 1'b1, 1'b0, q, k);
		chk({7'h00, k}, 8'h00);
		xfer(ADCRC_SCRATCH_OFFSET, 1'b1, 1'b0, q, k);
		xfer(8'h7f, 1'b1, 1'b0, q, k);
		cond(1'b1);
		clk_en = 1'b1;
		tick(4);
		rc(ADCRC_SCRATCH_OFFSET, 8'h55);
		rc(ADCRC_CONTROL_OFFSET, 8'h33);
		wb(ADCRC_SCRATCH_OFFSET, 8'h81);
		rc(ADCRC_SCRATCH_OFFSET, 8'h00);
		rc(ADCRC_CONTROL_OFFSET, 8'h20);
		rc(ADCRC_RESULT_LOW_OFFSET, 8'h00);
		chk(8'(n_reload), 8'h01);
		$display("test scratch_reload done");
		end_sim();
	end
	initial begin
		tick(60000);
		n_errors++;
		end_sim();
	end
endmodule
